// file: hdl/sic_top.sv
/*
  Interrupt enable, flag and system integration logic of the oscillator and
  system-control unit, reached over a 32-bit classic Wishbone slave.
  Assumes the bus clock is gated by the power manager and that the loop and
  brown-out domain edges arrive as one-cycle tick pulses on the one clock.
*/
`timescale 1ns/1ps
module sic_top
  import sic_pkg::*;
#(
  parameter int CFG_W      = SIC_CFG_W,
  parameter int SYNC_TICKS = SIC_SYNC_TICKS
)
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              srst,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   wb_err_o,
  // access guard
  input  wire logic              write_protect,
  // loop events and domain ticks
  input  sic_fll_event_type      fll_event,
  input  wire logic              fll_tick,
  input  wire logic              bod_tick,
  input  wire logic              source_clock_running,
  // sleep, debug and plug detection
  input  wire logic              standby_sleep,
  input  wire logic              debug_halt,
  input  wire logic              cold_plug_detected,
  input  wire logic              hot_plug_detected,
  // brown-out resets
  input  wire logic              bod_main_reset_req,
  input  wire logic              bod_core_reset_req,
  output logic                   bod_main_reset,
  output logic                   bod_core_reset,
  // domain configuration outputs
  output logic [CFG_W-1:0]       fll_cfg,
  output logic [CFG_W-1:0]       bod_cfg,
  // oscillator run requests and pin control
  output logic                   crystal_oscillator_run,
  output logic                   crystal_oscillator_32k_run,
  output logic                   crystal_oscillator_pin_ctrl,
  output logic                   crystal_oscillator_32k_pin_ctrl,
  // interrupt, wake and events
  output logic                   irq,
  output logic                   wake_request,
  output sic_fll_event_type      event_out
);

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic [31:0] ev_word(input sic_fll_event_type e);
    logic [31:0] w;
    w = SIC_RST_ZERO;
    w[SIC_BIT_REFCLK_STOP] = e.refclk_stop;
    w[SIC_BIT_COARSE_LOCK] = e.coarse_lock;
    w[SIC_BIT_FINE_LOCK]   = e.fine_lock;
    w[SIC_BIT_OUT_BOUNDS]  = e.out_bounds;
    w[SIC_BIT_FLL_READY]   = e.fll_ready;
    ev_word = w;
  endfunction

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  logic                     req;
  logic                     resp_r;
  logic                     err_r;
  logic [31:0]              rdata_r;
  logic [31:0]              wmask;
  logic [31:0]              wbits;
  logic                     hit_en_clr;
  logic                     hit_en_set;
  logic                     hit_flag;
  logic                     hit_ctl;
  logic                     hit_sts;
  logic                     hit_fll;
  logic                     hit_bod;
  logic                     guarded;
  logic                     blocked;
  logic                     wr_ok;
  logic [31:0]              irq_en_r;
  logic [31:0]              irq_flag_r;
  logic [31:0]              ctl_r;
  logic [31:0]              status;
  logic [CFG_W-1:0]         fll_hold_r;
  logic [CFG_W-1:0]         bod_hold_r;
  logic [CFG_W-1:0]         fll_cfg_r;
  logic [CFG_W-1:0]         bod_cfg_r;
  logic [1:0]               fll_cnt_r;
  logic [1:0]               bod_cnt_r;
  sic_sync_state_type       fll_state_r;
  sic_sync_state_type       bod_state_r;
  logic                     bod_mask_r;
  logic                     unit_alive;
  sic_fll_event_type        event_r;

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  assign req        = wb_cyc_i & wb_stb_i & ~resp_r;
  assign wmask      = lane_mask(wb_sel_i);
  assign wbits      = wb_dat_i & wmask;
  assign hit_en_clr = (wb_adr_i == SIC_OFS_IRQ_EN_CLR);
  assign hit_en_set = (wb_adr_i == SIC_OFS_IRQ_EN_SET);
  assign hit_flag   = (wb_adr_i == SIC_OFS_IRQ_FLAG);
  assign hit_ctl    = (wb_adr_i == SIC_OFS_CONTROL);
  assign hit_sts    = (wb_adr_i == SIC_OFS_STATUS);
  assign hit_fll    = (wb_adr_i == SIC_OFS_FLL_CTRL);
  assign hit_bod    = (wb_adr_i == SIC_OFS_BOD_CTRL);

  // the flag register is never guarded so pending interrupts can always be cleared
  assign guarded = hit_en_clr | hit_en_set | hit_ctl | hit_fll | hit_bod;
  assign blocked = wb_we_i & guarded & write_protect;
  assign wr_ok   = req & wb_we_i & ~blocked;

  // ---------------------------------------------------------------------------
  // bus response
  // ---------------------------------------------------------------------------
  // access only happens while the power manager runs the bus clock
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      resp_r <= 1'b0;
      err_r  <= 1'b0;
    end
    else
    begin
      resp_r <= req;
      err_r  <= req & blocked;
    end
  end

  assign wb_ack_o = resp_r & ~err_r;
  assign wb_err_o = resp_r & err_r;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rdata_r <= SIC_RST_ZERO;
    end
    else if (req & ~wb_we_i)
    begin
      rdata_r <= SIC_RST_ZERO;
      if (hit_en_clr | hit_en_set)
      begin
        rdata_r <= irq_en_r;
      end
      if (hit_flag)
      begin
        rdata_r <= irq_flag_r;
      end
      if (hit_ctl)
      begin
        rdata_r <= ctl_r;
      end
      if (hit_sts)
      begin
        rdata_r <= status;
      end
      if (hit_fll)
      begin
        rdata_r[CFG_W-1:0] <= fll_hold_r;
      end
      if (hit_bod)
      begin
        rdata_r[CFG_W-1:0] <= bod_hold_r;
      end
    end
  end

  assign wb_dat_o = rdata_r;

  // ---------------------------------------------------------------------------
  // interrupt enables
  // ---------------------------------------------------------------------------
  // only ones clear; a zero bit keeps the enable
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      irq_en_r <= SIC_RST_ZERO;
    end
    else if (wr_ok & hit_en_clr)
    begin
      irq_en_r <= irq_en_r & ~(wbits & SIC_IRQ_MASK);
    end
    else if (wr_ok & hit_en_set)
    begin
      irq_en_r <= irq_en_r | (wbits & SIC_IRQ_MASK);
    end
  end

  // ---------------------------------------------------------------------------
  // interrupt flags
  // ---------------------------------------------------------------------------
  // events are counted even during debug halt, which has no effect here
  assign unit_alive = source_clock_running;

  // a new event wins over a one-written clear in the same cycle
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      irq_flag_r <= SIC_RST_ZERO;
    end
    else
    begin
      irq_flag_r <= (irq_flag_r & ~((wr_ok & hit_flag) ? (wbits & SIC_IRQ_MASK) : SIC_RST_ZERO))
                  | (unit_alive ? ev_word(fll_event) : SIC_RST_ZERO);
    end
  end

  assign irq          = |(irq_flag_r & irq_en_r & SIC_IRQ_MASK);
  // the request line stays combinational so it works with sleeping bus logic
  assign wake_request = irq;

  // ---------------------------------------------------------------------------
  // event outputs
  // ---------------------------------------------------------------------------
  // events ignore the enables and never drive the wake line
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      event_r <= '0;
    end
    else
    begin
      event_r <= unit_alive ? fll_event : '0;
    end
  end

  assign event_out = event_r;

  // ---------------------------------------------------------------------------
  // control register and oscillators
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ctl_r <= SIC_RST_ZERO;
    end
    else if (wr_ok & hit_ctl)
    begin
      ctl_r <= (ctl_r & ~(wmask & SIC_CTL_MASK)) | (wbits & SIC_CTL_MASK);
    end
  end

  assign crystal_oscillator_run    = ctl_r[SIC_CTL_CRYSTAL_OSCILLATOR_EN] & (~standby_sleep | ctl_r[SIC_CTL_CRYSTAL_OSCILLATOR_STBY]);
  assign crystal_oscillator_32k_run = ctl_r[SIC_CTL_CRYSTAL_OSCILLATOR_32K_EN] & (~standby_sleep | ctl_r[SIC_CTL_CRYSTAL_OSCILLATOR_32K_STBY]);

  // pins follow the enable so no separate port setup is needed
  assign crystal_oscillator_pin_ctrl    = ctl_r[SIC_CTL_CRYSTAL_OSCILLATOR_EN];
  assign crystal_oscillator_32k_pin_ctrl = ctl_r[SIC_CTL_CRYSTAL_OSCILLATOR_32K_EN];

  // ---------------------------------------------------------------------------
  // loop domain synchronization
  // ---------------------------------------------------------------------------
  // a write restarts the handover; the domain copy changes only on its own tick
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      fll_hold_r  <= SIC_RST_CFG;
      fll_cfg_r   <= SIC_RST_CFG;
      fll_cnt_r   <= 2'h0;
      fll_state_r <= SIC_SYNC_IDLE;
    end
    else if (wr_ok & hit_fll)
    begin
      fll_hold_r  <= wb_dat_i[CFG_W-1:0];
      fll_cnt_r   <= 2'h0;
      fll_state_r <= SIC_SYNC_BUSY;
    end
    else
    begin
      case (fll_state_r)
        SIC_SYNC_BUSY:
        begin
          if (fll_tick)
          begin
            if (fll_cnt_r == 2'(SYNC_TICKS - 1))
            begin
              fll_cfg_r   <= fll_hold_r;
              fll_state_r <= SIC_SYNC_IDLE;
            end
            else
            begin
              fll_cnt_r <= fll_cnt_r + 2'h1;
            end
          end
        end
        SIC_SYNC_IDLE:
        begin
          fll_cnt_r <= 2'h0;
        end
        default:
        begin
          fll_state_r <= SIC_SYNC_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // brown-out domain synchronization
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      bod_hold_r  <= SIC_RST_CFG;
      bod_cfg_r   <= SIC_RST_CFG;
      bod_cnt_r   <= 2'h0;
      bod_state_r <= SIC_SYNC_IDLE;
    end
    else if (wr_ok & hit_bod)
    begin
      bod_hold_r  <= wb_dat_i[CFG_W-1:0];
      bod_cnt_r   <= 2'h0;
      bod_state_r <= SIC_SYNC_BUSY;
    end
    else
    begin
      case (bod_state_r)
        SIC_SYNC_BUSY:
        begin
          if (bod_tick)
          begin
            if (bod_cnt_r == 2'(SYNC_TICKS - 1))
            begin
              bod_cfg_r   <= bod_hold_r;
              bod_state_r <= SIC_SYNC_IDLE;
            end
            else
            begin
              bod_cnt_r <= bod_cnt_r + 2'h1;
            end
          end
        end
        SIC_SYNC_IDLE:
        begin
          bod_cnt_r <= 2'h0;
        end
        default:
        begin
          bod_state_r <= SIC_SYNC_IDLE;
        end
      endcase
    end
  end

  assign fll_cfg = fll_cfg_r;
  assign bod_cfg = bod_cfg_r;

  // ---------------------------------------------------------------------------
  // brown-out reset masking
  // ---------------------------------------------------------------------------
  // cold plug masks until the next reset; hot plug never masks
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      bod_mask_r <= 1'b0;
    end
    else if (cold_plug_detected & ~hot_plug_detected)
    begin
      bod_mask_r <= 1'b1;
    end
  end

  assign bod_main_reset = bod_main_reset_req & ~bod_mask_r;
  assign bod_core_reset = bod_core_reset_req & ~bod_mask_r;

  // ---------------------------------------------------------------------------
  // status
  // ---------------------------------------------------------------------------
  always_comb
  begin
    status                      = SIC_RST_ZERO;
    status[SIC_STS_FLL_BUSY]    = (fll_state_r == SIC_SYNC_BUSY);
    status[SIC_STS_BOD_BUSY]    = (bod_state_r == SIC_SYNC_BUSY);
    status[SIC_STS_BOD_MASKED]  = bod_mask_r;
    status[SIC_STS_CRYSTAL_OSCILLATOR_RUN]    = crystal_oscillator_run;
    status[SIC_STS_CRYSTAL_OSCILLATOR_32K_RUN] = crystal_oscillator_32k_run;
    status[SIC_STS_SRC_RUN]     = source_clock_running & ~(debug_halt & 1'b0);
  end

endmodule

// file: include/sic_pkg.sv
/*
  Constants and types shared by the oscillator and system-control interrupt unit:
  register byte offsets, bit positions, reset values and the event carrier.
  Assumes a 32-bit classic Wishbone bus and one 100 MHz clock.
*/
// -----------------------------------------------------------------------------
// Summary of operation
// -----------------------------------------------------------------------------
package sic_pkg;

  // ---------------------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SIC_OFS_IRQ_EN_CLR  = 8'h00;
  localparam logic [7:0] SIC_OFS_IRQ_EN_SET  = 8'h04;
  localparam logic [7:0] SIC_OFS_IRQ_FLAG    = 8'h08;
  localparam logic [7:0] SIC_OFS_CONTROL     = 8'h0C;
  localparam logic [7:0] SIC_OFS_STATUS      = 8'h10;
  localparam logic [7:0] SIC_OFS_FLL_CTRL    = 8'h14;
  localparam logic [7:0] SIC_OFS_BOD_CTRL    = 8'h18;

  // ---------------------------------------------------------------------------
  // interrupt bit positions (enable, set and flag share one layout)
  // ---------------------------------------------------------------------------
  localparam int SIC_BIT_REFCLK_STOP = 8;
  localparam int SIC_BIT_COARSE_LOCK = 7;
  localparam int SIC_BIT_FINE_LOCK   = 6;
  localparam int SIC_BIT_OUT_BOUNDS  = 5;
  localparam int SIC_BIT_FLL_READY   = 4;
  localparam logic [31:0] SIC_IRQ_MASK = 32'h0000_01F0;

  // ---------------------------------------------------------------------------
  // control and status bit positions
  // ---------------------------------------------------------------------------
  localparam int SIC_CTL_CRYSTAL_OSCILLATOR_EN     = 0;
  localparam int SIC_CTL_CRYSTAL_OSCILLATOR_32K_EN  = 1;
  localparam int SIC_CTL_CRYSTAL_OSCILLATOR_STBY   = 2;
  localparam int SIC_CTL_CRYSTAL_OSCILLATOR_32K_STBY = 3;
  localparam logic [31:0] SIC_CTL_MASK = 32'h0000_000F;
  localparam int SIC_STS_FLL_BUSY    = 0;
  localparam int SIC_STS_BOD_BUSY    = 1;
  localparam int SIC_STS_BOD_MASKED  = 2;
  localparam int SIC_STS_CRYSTAL_OSCILLATOR_RUN    = 3;
  localparam int SIC_STS_CRYSTAL_OSCILLATOR_32K_RUN = 4;
  localparam int SIC_STS_SRC_RUN     = 5;

  // ---------------------------------------------------------------------------
  // reset values and widths
  // ---------------------------------------------------------------------------
  localparam int          SIC_CFG_W      = 16;
  localparam logic [31:0] SIC_RST_ZERO   = 32'h0000_0000;
  localparam logic [15:0] SIC_RST_CFG    = 16'h0000;
  localparam int          SIC_SYNC_TICKS = 2;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic refclk_stop;
    logic coarse_lock;
    logic fine_lock;
    logic out_bounds;
    logic fll_ready;
  } sic_fll_event_type;

  typedef enum logic [1:0] {
    SIC_SYNC_IDLE = 2'b01,
    SIC_SYNC_BUSY = 2'b10
  } sic_sync_state_type;

endpackage

// file: verif/sic_top_asserts.sv
/*
  Concurrent checks on the ports of the interrupt and system-control unit.
  Assumes one clock, srst synchronous active high, bound onto sic_top.
*/
`timescale 1ns/1ps
module sic_top_asserts
  import sic_pkg::*;
#(
  parameter int CFG_W = SIC_CFG_W
)
(
  // clock, reset and bus
  input wire logic             clock,
  input wire logic             srst,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [7:0]       wb_adr_i,
  input wire logic             wb_ack_o,
  input wire logic             wb_err_o,
  input wire logic             write_protect,
  // events and domains
  input sic_fll_event_type     fll_event,
  input sic_fll_event_type     event_out,
  input wire logic             source_clock_running,
  input wire logic             fll_tick,
  input wire logic             bod_tick,
  input wire logic [CFG_W-1:0] fll_cfg,
  input wire logic [CFG_W-1:0] bod_cfg,
  // sleep, plug and outputs
  input wire logic             standby_sleep,
  input wire logic             cold_plug_detected,
  input wire logic             hot_plug_detected,
  input wire logic             bod_main_reset,
  input wire logic             bod_core_reset,
  input wire logic             crystal_oscillator_run,
  input wire logic             crystal_oscillator_32k_run,
  input wire logic             crystal_oscillator_pin_ctrl,
  input wire logic             crystal_oscillator_32k_pin_ctrl,
  input wire logic             irq,
  input wire logic             wake_request
);
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  logic taken;
  assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  property p_wake; irq == wake_request; endproperty
  a_wake: assert property (p_wake) else $error("wake differs from irq");
  property p_pin; crystal_oscillator_run |-> crystal_oscillator_pin_ctrl; endproperty
  a_pin: assert property (p_pin) else $error("oscillator runs without pins");
  property p_stby; !standby_sleep |-> crystal_oscillator_run == crystal_oscillator_pin_ctrl && crystal_oscillator_32k_run == crystal_oscillator_32k_pin_ctrl; endproperty
  a_stby: assert property (p_stby) else $error("run differs from enable outside standby");
  property p_cold; cold_plug_detected && !hot_plug_detected |-> ##2 !bod_main_reset && !bod_core_reset; endproperty
  a_cold: assert property (p_cold) else $error("brown-out reset not masked");
  property p_event; source_clock_running |=> event_out == $past(fll_event); endproperty
  a_event: assert property (p_event) else $error("event not passed on");
  property p_ev_stop; !source_clock_running |=> event_out == 5'h00; endproperty
  a_ev_stop: assert property (p_ev_stop) else $error("event while source stopped");
  property p_fll_sync; !fll_tick |=> $stable(fll_cfg); endproperty
  a_fll_sync: assert property (p_fll_sync) else $error("loop config moved off tick");
  property p_bod_sync; !bod_tick |=> $stable(bod_cfg); endproperty
  a_bod_sync: assert property (p_bod_sync) else $error("brown-out config moved off tick");
  property p_flag_ok; taken && wb_we_i && wb_adr_i == SIC_OFS_IRQ_FLAG |=> wb_ack_o && !wb_err_o; endproperty
  a_flag_ok: assert property (p_flag_ok) else $error("flag write refused");
  property p_prot; taken && wb_we_i && write_protect && wb_adr_i == SIC_OFS_IRQ_EN_SET |=> wb_err_o; endproperty
  a_prot: assert property (p_prot) else $error("guarded write accepted");
  property p_read; taken && !wb_we_i |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_read: assert property (p_read) else $error("read answer not one cycle");
endmodule

bind sic_top sic_top_asserts #(.CFG_W(CFG_W)) u_chk (.clock, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_ack_o, .wb_err_o, .write_protect, .fll_event, .event_out, .source_clock_running, .fll_tick, .bod_tick,
  .fll_cfg, .bod_cfg, .standby_sleep, .cold_plug_detected, .hot_plug_detected, .bod_main_reset,
  .bod_core_reset, .crystal_oscillator_run, .crystal_oscillator_32k_run, .crystal_oscillator_pin_ctrl, .crystal_oscillator_32k_pin_ctrl, .irq, .wake_request);

// file: verif/sic_top_bench.sv
/*
  Self-checking bench for sic_top: bus cycles, enables, flags, sleep, sync, plug.
  Assumes the checker is bound in by its own file; one 100 MHz clock.
*/
`timescale 1ns/1ps
module sic_top_bench
  import sic_pkg::*;
;
  logic              clock, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, re;
  logic              write_protect, fll_tick, bod_tick, source_clock_running, standby_sleep, debug_halt;
  logic              cold_plug_detected, hot_plug_detected, bod_main_reset_req, bod_core_reset_req;
  logic              bod_main_reset, bod_core_reset, crystal_oscillator_run, crystal_oscillator_32k_run, crystal_oscillator_pin_ctrl, crystal_oscillator_32k_pin_ctrl;
  logic              irq, wake_request;
  logic [7:0]        wb_adr_i;
  logic [3:0]        wb_sel_i;
  logic [31:0]       wb_dat_i, wb_dat_o, rq, en, d;
  logic [15:0]       fll_cfg, bod_cfg, cv;
  sic_fll_event_type fll_event, event_out;
  int                fails, n_tests, seed, i, b;

  sic_top dut (.clock(clock), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .write_protect(write_protect), .fll_event(fll_event), .fll_tick(fll_tick),
    .bod_tick(bod_tick), .source_clock_running(source_clock_running), .standby_sleep(standby_sleep),
    .debug_halt(debug_halt), .cold_plug_detected(cold_plug_detected), .hot_plug_detected(hot_plug_detected),
    .bod_main_reset_req(bod_main_reset_req), .bod_core_reset_req(bod_core_reset_req),
    .bod_main_reset(bod_main_reset), .bod_core_reset(bod_core_reset), .fll_cfg(fll_cfg), .bod_cfg(bod_cfg),
    .crystal_oscillator_run(crystal_oscillator_run), .crystal_oscillator_32k_run(crystal_oscillator_32k_run), .crystal_oscillator_pin_ctrl(crystal_oscillator_pin_ctrl),
    .crystal_oscillator_32k_pin_ctrl(crystal_oscillator_32k_pin_ctrl), .irq(irq), .wake_request(wake_request), .event_out(event_out));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ---------------------------------------------------------------------------
  // expectations and checks
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] f_en(input logic [31:0] e, input logic [31:0] v, input int s);
    return s ? (e | (v & SIC_IRQ_MASK)) : (e & ~(v & SIC_IRQ_MASK));
  endfunction
  function automatic logic f_run(input logic e, input logic st, input logic s);
    return e & (!s | st);
  endfunction
  task end_of_test;
    if (fails == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // ---------------------------------------------------------------------------
  // bus cycle, event pulse, sync transfer
  // ---------------------------------------------------------------------------
  task wb(input logic we, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= v;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (!(wb_ack_o || wb_err_o) && n < 50);
    if (n >= 50)
    begin
      fails++;
      end_of_test;
    end
    rq = wb_dat_o;
    re = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask
  task ev(input int k);
    fll_event <= 5'(1 << (k - 4));
    @(posedge clock);
    fll_event <= 5'h00;
    @(posedge clock);
    chk(32'(event_out), source_clock_running ? 32'(1 << (k - 4)) : 32'h0);
  endtask
  task sy(input logic [7:0] a, input int k);
    cv = 16'($random(seed));
    wb(1'b1, a, 32'(cv));
    wb(1'b0, SIC_OFS_STATUS, 32'h0);
    chk(32'(rq[k]), 32'h1);
    repeat (SIC_SYNC_TICKS)
    begin
      fll_tick <= (k == 0);
      bod_tick <= (k == 1);
      @(posedge clock);
      fll_tick <= 1'b0;
      bod_tick <= 1'b0;
      @(posedge clock);
    end
    chk(32'(k == 0 ? fll_cfg : bod_cfg), 32'(cv));
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    seed = 34;
    fails = 0;
    n_tests = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, write_protect, fll_tick, bod_tick, standby_sleep, debug_halt} = 8'h00;
    {cold_plug_detected, bod_main_reset_req, bod_core_reset_req} = 3'h0;
    {srst, source_clock_running, hot_plug_detected} = 3'h7;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    fll_event = 5'h00;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    for (i = 0; i < 8; i++)
    begin
      wb(1'b0, 8'(i * 4), 32'h0);
      chk(rq, (i == 4) ? 32'h20 : 32'h0);
    end
    en = 32'h0;
    for (i = 0; i < 24; i++)
    begin
      d = (i == 3) ? 32'h0 : $random(seed);
      wb(1'b1, i[0] ? SIC_OFS_IRQ_EN_SET : SIC_OFS_IRQ_EN_CLR, d);
      en = f_en(en, d, i[0]);
      wb(1'b0, SIC_OFS_IRQ_EN_CLR, 32'h0);
      chk(rq, en);
    end
    debug_halt <= 1'b1;
    standby_sleep <= 1'b1;
    for (b = 4; b < 9; b++)
    begin
      wb(1'b1, SIC_OFS_IRQ_EN_SET, SIC_IRQ_MASK);
      wb(1'b1, SIC_OFS_IRQ_EN_CLR, 32'h1 << b);
      wb(1'b0, SIC_OFS_IRQ_EN_CLR, 32'h0);
      chk(rq, f_en(SIC_IRQ_MASK, 32'h1 << b, 0));
      ev(b);
      chk(32'(irq), 32'h0);
      wb(1'b0, SIC_OFS_IRQ_FLAG, 32'h0);
      chk(rq, 32'h1 << b);
      wb(1'b1, SIC_OFS_IRQ_EN_SET, 32'h1 << b);
      chk(32'({wake_request, irq}), 32'h3);
      wb(1'b1, SIC_OFS_IRQ_FLAG, 32'h1 << b);
      chk(32'(irq), 32'h0);
    end
    source_clock_running <= 1'b0;
    ev(5);
    wb(1'b0, SIC_OFS_IRQ_FLAG, 32'h0);
    chk(rq, 32'h0);
    source_clock_running <= 1'b1;
    write_protect <= 1'b1;
    wb(1'b1, SIC_OFS_IRQ_EN_SET, SIC_IRQ_MASK);
    chk(32'(re), 32'h1);
    ev(7);
    wb(1'b1, SIC_OFS_IRQ_FLAG, SIC_IRQ_MASK);
    chk(32'({re, irq}), 32'h0);
    write_protect <= 1'b0;
    for (i = 0; i < 32; i++)
    begin
      wb(1'b1, SIC_OFS_CONTROL, 32'(i));
      standby_sleep <= i[4];
      @(posedge clock);
      d = 32'(i);
      chk(32'({crystal_oscillator_run, crystal_oscillator_32k_run, crystal_oscillator_pin_ctrl, crystal_oscillator_32k_pin_ctrl}),
          32'({f_run(d[0], d[2], d[4]), f_run(d[1], d[3], d[4]), d[0], d[1]}));
    end
    sy(SIC_OFS_FLL_CTRL, SIC_STS_FLL_BUSY);
    sy(SIC_OFS_BOD_CTRL, SIC_STS_BOD_BUSY);
    bod_main_reset_req <= 1'b1;
    bod_core_reset_req <= 1'b1;
    cold_plug_detected <= 1'b1;
    repeat (3) @(posedge clock);
    chk(32'({bod_main_reset, bod_core_reset}), 32'h3);
    hot_plug_detected <= 1'b0;
    repeat (3) @(posedge clock);
    chk(32'({bod_main_reset, bod_core_reset}), 32'h0);
    wb(1'b0, SIC_OFS_STATUS, 32'h0);
    chk(rq, 32'h3C);
    srst <= 1'b1;
    cold_plug_detected <= 1'b0;
    hot_plug_detected <= 1'b1;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    repeat (2) @(posedge clock);
    chk(32'({bod_main_reset, bod_core_reset}), 32'h3);
    end_of_test;
  end
endmodule
